// ===== pecd_pkg.sv
// pecd_pkg: constants and carrier types for the pin edge change detector.
// assumes an 8-bit register port with a 4-bit word address; one register per address.
`default_nettype none

package pecd_pkg;

   // widths
   localparam int PIN_W  = 8;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int ALL_W  = 2 * PIN_W;

   // register addresses
   localparam logic [ADDR_W-1:0] ADDR_PORTA_RISE   = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_PORTA_FALL   = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_PORTA_FLAGS  = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_PORTB_RISE   = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_PORTB_FALL   = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_PORTB_FLAGS  = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS   = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK     = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_PORTA_LEVEL  = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_PORTB_LEVEL  = 4'h9;
   localparam logic [ADDR_W-1:0] ADDR_CHANGE_FLAG  = 4'hA;

   // reset values
   localparam logic [DATA_W-1:0] RST_BYTE   = 8'h00;
   localparam logic [ALL_W-1:0]  RST_PINS   = 16'h0000;
   localparam logic [DATA_W-1:0] READ_ZERO  = 8'h00;

   // interrupt status / mask bit positions
   localparam int IRQ_PORTA_BIT = 0;
   localparam int IRQ_PORTB_BIT = 1;
   localparam logic [DATA_W-1:0] IRQ_BITS_USED = 8'h03;

   // last settle count after reset; edges are reported from the cycle after it is reached (synchroniser fill)
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;

   // settle state machine, one-hot
   typedef enum logic [1:0] {
      PECD_ST_SETTLE = 2'b01,
      PECD_ST_RUN    = 2'b10
   } pecd_state_t;

   // register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } pecd_bus_req_t;

   // pin sample group
   typedef struct packed {
      logic [PIN_W-1:0] portb;
      logic [PIN_W-1:0] porta;
   } pecd_pins_t;

endpackage : pecd_pkg

`default_nettype wire

// ===== pecd_detector.sv
// pecd_detector: edge change detector for two 8-pin ports with sticky flags and one interrupt.
// assumes pins are asynchronous to sys_clk; register port master follows the one-cycle strobe protocol.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pecd_detector (
   // clock and reset
   input  wire logic                       sys_clk,
   input  wire logic                       rst,
   // register port
   input  wire pecd_pkg::pecd_bus_req_t    bus_req,
   output var  logic [pecd_pkg::DATA_W-1:0] rd_data,
   // port pins
   input  wire pecd_pkg::pecd_pins_t       pins,
   // interrupt
   output var  logic                       irq,
   output var  logic                       change_interrupt_flag
);

   import pecd_pkg::*;

   // enable and flag registers
   logic [PIN_W-1:0] porta_rise_enable_reg;
   logic [PIN_W-1:0] porta_fall_enable_reg;
   logic [PIN_W-1:0] porta_change_flag_reg;
   logic [PIN_W-1:0] porta_change_flag_next;
   logic [PIN_W-1:0] portb_rise_enable_reg;
   logic [PIN_W-1:0] portb_fall_enable_reg;
   logic [PIN_W-1:0] portb_change_flag_reg;
   logic [PIN_W-1:0] portb_change_flag_next;

   // interrupt status and mask
   logic [DATA_W-1:0] irq_status_reg;
   logic [DATA_W-1:0] irq_status_next;
   logic [DATA_W-1:0] irq_mask_reg;
   logic [DATA_W-1:0] irq_mask_next;
   logic [DATA_W-1:0] irq_event;

   // read path
   logic [DATA_W-1:0] rd_data_reg;
   logic [DATA_W-1:0] rd_data_next;
   logic              irq_reg;
   logic              cif_reg;

   // synchroniser and edge detection
   logic [ALL_W-1:0] pin_vec;
   logic [ALL_W-1:0] sync1_reg;
   logic [ALL_W-1:0] sync2_reg;
   logic [ALL_W-1:0] sync3_reg;
   logic [ALL_W-1:0] level_reg;
   logic [ALL_W-1:0] rise_det;
   logic [ALL_W-1:0] fall_det;

   // settle control
   pecd_state_t      state_reg;
   logic [1:0]       settle_cnt_reg;
   logic             run;

   // register write decode
   logic wr_porta_rise;
   logic wr_porta_fall;
   logic wr_porta_flags;
   logic wr_portb_rise;
   logic wr_portb_fall;
   logic wr_portb_flags;
   logic wr_irq_status;
   logic wr_irq_mask;

   // per-port edge hits
   logic [PIN_W-1:0] porta_hit;
   logic [PIN_W-1:0] portb_hit;

   assign pin_vec = {pins.portb, pins.porta};
   assign run     = (state_reg == PECD_ST_RUN);

   // ------------------------------------------------------------------
   // settle: synchroniser stages hold reset zeros, so edges are muted
   // until every stage has seen the real pin level
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg      <= PECD_ST_SETTLE;
         settle_cnt_reg <= 2'h0;
      end else begin
         case (state_reg)
            PECD_ST_SETTLE: begin
               if (settle_cnt_reg == SETTLE_CYCLES) begin
                  state_reg <= PECD_ST_RUN;
               end else begin
                  settle_cnt_reg <= settle_cnt_reg + 2'h1;
               end
            end
            PECD_ST_RUN: begin
               state_reg <= PECD_ST_RUN;
            end
            default: begin
               state_reg      <= PECD_ST_SETTLE;
               settle_cnt_reg <= 2'h0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // per-pin three-stage synchroniser and edge detector
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < ALL_W; gi = gi + 1) begin : g_pin
         logic agree;

         // first stage feeds only the second
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
               sync3_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= pin_vec[gi];
               sync2_reg[gi] <= sync1_reg[gi];
               sync3_reg[gi] <= sync2_reg[gi];
            end
         end

         assign agree = (sync2_reg[gi] == sync3_reg[gi]);

         // accepted level moves only when stages two and three agree
         always_ff @(posedge sys_clk) begin
            if (rst) begin
               level_reg[gi] <= 1'b0;
            end else if (agree) begin
               level_reg[gi] <= sync3_reg[gi];
            end
         end

         // level_reg follows at once, so each edge yields one pulse
         assign rise_det[gi] = run & agree & sync3_reg[gi] & ~level_reg[gi];
         assign fall_det[gi] = run & agree & ~sync3_reg[gi] & level_reg[gi];
      end
   endgenerate

   // ------------------------------------------------------------------
   // enabled edges per port
   // ------------------------------------------------------------------
   assign porta_hit = (rise_det[PIN_W-1:0] & porta_rise_enable_reg)
                    | (fall_det[PIN_W-1:0] & porta_fall_enable_reg);

   assign portb_hit = (rise_det[ALL_W-1:PIN_W] & portb_rise_enable_reg)
                    | (fall_det[ALL_W-1:PIN_W] & portb_fall_enable_reg);

   // ------------------------------------------------------------------
   // register write decode
   // ------------------------------------------------------------------
   // unmapped and read-only addresses decode to no write at all
   assign wr_porta_rise  = bus_req.wr & (bus_req.addr == ADDR_PORTA_RISE);
   assign wr_porta_fall  = bus_req.wr & (bus_req.addr == ADDR_PORTA_FALL);
   assign wr_porta_flags = bus_req.wr & (bus_req.addr == ADDR_PORTA_FLAGS);
   assign wr_portb_rise  = bus_req.wr & (bus_req.addr == ADDR_PORTB_RISE);
   assign wr_portb_fall  = bus_req.wr & (bus_req.addr == ADDR_PORTB_FALL);
   assign wr_portb_flags = bus_req.wr & (bus_req.addr == ADDR_PORTB_FLAGS);
   assign wr_irq_status  = bus_req.wr & (bus_req.addr == ADDR_IRQ_STATUS);
   assign wr_irq_mask    = bus_req.wr & (bus_req.addr == ADDR_IRQ_MASK);

   // ------------------------------------------------------------------
   // edge enables
   // ------------------------------------------------------------------
   // an enable write lands at the strobe edge, so the next accepted pin edge already sees it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         porta_rise_enable_reg <= RST_BYTE;
      end else if (wr_porta_rise) begin
         porta_rise_enable_reg <= bus_req.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         porta_fall_enable_reg <= RST_BYTE;
      end else if (wr_porta_fall) begin
         porta_fall_enable_reg <= bus_req.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         portb_rise_enable_reg <= RST_BYTE;
      end else if (wr_portb_rise) begin
         portb_rise_enable_reg <= bus_req.wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         portb_fall_enable_reg <= RST_BYTE;
      end else if (wr_portb_fall) begin
         portb_fall_enable_reg <= bus_req.wdata;
      end
   end

   // ------------------------------------------------------------------
   // change flags: a written zero clears, a written one keeps;
   // a hit in the same cycle as the clear wins
   // ------------------------------------------------------------------
   always_comb begin
      porta_change_flag_next = porta_change_flag_reg;
      if (wr_porta_flags) begin
         porta_change_flag_next = porta_change_flag_reg & bus_req.wdata;
      end
      porta_change_flag_next = porta_change_flag_next | porta_hit;
   end

   always_comb begin
      portb_change_flag_next = portb_change_flag_reg;
      if (wr_portb_flags) begin
         portb_change_flag_next = portb_change_flag_reg & bus_req.wdata;
      end
      portb_change_flag_next = portb_change_flag_next | portb_hit;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         porta_change_flag_reg <= RST_BYTE;
      end else begin
         porta_change_flag_reg <= porta_change_flag_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         portb_change_flag_reg <= RST_BYTE;
      end else begin
         portb_change_flag_reg <= portb_change_flag_next;
      end
   end

   // shared flag stands while any pin flag of either port is set
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cif_reg <= 1'b0;
      end else begin
         cif_reg <= (|porta_change_flag_next) | (|portb_change_flag_next);
      end
   end

   // ------------------------------------------------------------------
   // interrupt status: sticky, write one to clear, new event wins
   // ------------------------------------------------------------------
   always_comb begin
      irq_event                = READ_ZERO;
      irq_event[IRQ_PORTA_BIT] = |porta_hit;
      irq_event[IRQ_PORTB_BIT] = |portb_hit;
      irq_status_next          = irq_status_reg;
      if (wr_irq_status) begin
         irq_status_next = irq_status_reg & ~bus_req.wdata;
      end
      irq_status_next = (irq_status_next | irq_event) & IRQ_BITS_USED;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_status_reg <= RST_BYTE;
      end else begin
         irq_status_reg <= irq_status_next;
      end
   end

   // irq is built from next-state status and mask, so it never lags a mask write by a cycle
   always_comb begin
      irq_mask_next = irq_mask_reg;
      if (wr_irq_mask) begin
         irq_mask_next = bus_req.wdata & IRQ_BITS_USED;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_mask_reg <= RST_BYTE;
      end else begin
         irq_mask_reg <= irq_mask_next;
      end
   end

   // level output: high while any unmasked status bit stands
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_status_next & irq_mask_next);
      end
   end

   // ------------------------------------------------------------------
   // read path: data stands in the cycle after the strobe only
   // ------------------------------------------------------------------
   always_comb begin
      rd_data_next = READ_ZERO;
      if (bus_req.rd) begin
         case (bus_req.addr)
            ADDR_PORTA_RISE:  rd_data_next = porta_rise_enable_reg;
            ADDR_PORTA_FALL:  rd_data_next = porta_fall_enable_reg;
            ADDR_PORTA_FLAGS: rd_data_next = porta_change_flag_reg;
            ADDR_PORTB_RISE:  rd_data_next = portb_rise_enable_reg;
            ADDR_PORTB_FALL:  rd_data_next = portb_fall_enable_reg;
            ADDR_PORTB_FLAGS: rd_data_next = portb_change_flag_reg;
            ADDR_IRQ_STATUS:  rd_data_next = irq_status_reg;
            ADDR_IRQ_MASK:    rd_data_next = irq_mask_reg;
            // level reads give the accepted pin state, not the raw pin
            ADDR_PORTA_LEVEL: rd_data_next = level_reg[PIN_W-1:0];
            ADDR_PORTB_LEVEL: rd_data_next = level_reg[ALL_W-1:PIN_W];
            ADDR_CHANGE_FLAG: rd_data_next = {7'h00, cif_reg};
            default:          rd_data_next = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_data_reg <= RST_BYTE;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign rd_data               = rd_data_reg;
   assign irq                   = irq_reg;
   assign change_interrupt_flag = cif_reg;

endmodule : pecd_detector

`default_nettype wire

// ===== pecd_asserts.sv
// pecd_asserts: port-level checker for pecd_detector, bound to every instance.
// assumes the one-cycle strobe register port and pin levels held two cycles or more.
`timescale 1ns/1ps
`default_nettype none
module pecd_checker (
   // clock and reset
   input wire logic                        sys_clk,
   input wire logic                        rst,
   // register port
   input wire pecd_pkg::pecd_bus_req_t     bus_req,
   input wire logic [pecd_pkg::DATA_W-1:0] rd_data,
   // pins and interrupt
   input wire pecd_pkg::pecd_pins_t        pins,
   input wire logic                        irq,
   input wire logic                        change_interrupt_flag
);
   import pecd_pkg::*;
   logic [PIN_W-1:0] ra_reg, fa_reg, rb_reg, fb_reg;
   logic [1:0]       mk_reg;
   logic [3:0]       run_reg;
   pecd_pins_t       pv_reg;
   logic             run, hit_a, hit_b, hit;
   // shadow of enables and mask as software wrote them
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         {ra_reg, fa_reg, rb_reg, fb_reg} <= {RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE};
         mk_reg <= 2'h0;
      end else if (bus_req.wr) begin
         if (bus_req.addr == ADDR_PORTA_RISE) ra_reg <= bus_req.wdata;
         if (bus_req.addr == ADDR_PORTA_FALL) fa_reg <= bus_req.wdata;
         if (bus_req.addr == ADDR_PORTB_RISE) rb_reg <= bus_req.wdata;
         if (bus_req.addr == ADDR_PORTB_FALL) fb_reg <= bus_req.wdata;
         if (bus_req.addr == ADDR_IRQ_MASK) mk_reg <= bus_req.wdata[1:0];
      end
   end
   // edges are only judged well after the settle time
   always_ff @(posedge sys_clk) begin
      pv_reg  <= pins;
      run_reg <= rst ? 4'h0 : (run_reg == 4'h8 ? run_reg : run_reg + 4'h1);
   end
   assign run   = (run_reg == 4'h8);
   assign hit_a = run && |((pins.porta & ~pv_reg.porta & ra_reg) | (~pins.porta & pv_reg.porta & fa_reg));
   assign hit_b = run && |((pins.portb & ~pv_reg.portb & rb_reg) | (~pins.portb & pv_reg.portb & fb_reg));
   assign hit   = hit_a || hit_b;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_reset_quiet: assert property (
      $fell(rst) |-> !irq && !change_interrupt_flag && rd_data == 8'h00) else $error("outputs not clear after reset");
   chk_read_idle: assert property (
      !$past(bus_req.rd) |-> rd_data == 8'h00) else $error("read data outside read slot");
   chk_flag_sticky: assert property (
      change_interrupt_flag && !bus_req.wr && !$past(bus_req.wr) |=> change_interrupt_flag)
      else $error("change flag dropped without write");
   chk_irq_sticky: assert property (
      irq && !bus_req.wr |=> irq) else $error("irq dropped without write");
   chk_porta_edge: assert property (
      hit_a |-> ##[3:5] change_interrupt_flag) else $error("porta edge not flagged");
   chk_portb_edge: assert property (
      hit_b |-> ##[3:5] change_interrupt_flag) else $error("portb edge not flagged");
   chk_portb_irq: assert property (
      hit_b && mk_reg[1] |-> ##[3:5] irq) else $error("portb edge without irq");
   chk_flag_cause: assert property (
      $rose(change_interrupt_flag) |-> $past(hit, 3) || $past(hit, 4) || $past(hit, 5))
      else $error("change flag without enabled edge");
   chk_irq_cause: assert property (
      $rose(irq) |-> $past(bus_req.wr) || $past(hit, 3) || $past(hit, 4) || $past(hit, 5))
      else $error("irq without cause");
   cover property (hit_a);
   cover property (hit_b && mk_reg[1]);
   cover property ($fell(change_interrupt_flag));
endmodule : pecd_checker
bind pecd_detector pecd_checker chk (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
   .pins(pins), .irq(irq), .change_interrupt_flag(change_interrupt_flag));
`default_nettype wire

// ===== pecd_pin_model.sv
// pecd_pin_model: far-side pin source for the detector bench.
// assumes drive requests come from one bench thread at a time.
`timescale 1ns/1ps
`default_nettype none
module pecd_pin_model (
   // clock
   input  wire logic                 sys_clk,
   // pins toward the detector
   output var  pecd_pkg::pecd_pins_t pins
);
   import pecd_pkg::*;
   initial pins = RST_PINS;
   // shorter pulses could slip through the synchroniser unseen
   task automatic drive(input pecd_pins_t v);
      @(posedge sys_clk);
      pins <= v;
      repeat (2) @(posedge sys_clk);
   endtask : drive
endmodule : pecd_pin_model
`default_nettype wire

// ===== testbench.sv
// testbench: random register and pin traffic against a behavioural model.
// assumes pecd_pkg, pecd_detector, pecd_pin_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pecd_pkg::*;
   logic              sys_clk, rst, irq, change_interrupt_flag;
   pecd_bus_req_t     bus_req;
   logic [DATA_W-1:0] rd_data;
   pecd_pins_t        pins;
   int                errors = 0, comparisons = 0, m[8], pa, pb;
   logic [31:0]       seed = 32'h4C0A, r;
   pecd_detector dut (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .pins(pins),
                      .irq(irq), .change_interrupt_flag(change_interrupt_flag));
   pecd_pin_model pm (.sys_clk(sys_clk), .pins(pins));
   always #50 sys_clk = ~sys_clk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic int exp_rd(input logic [3:0] a);
      if (a < 4'h8) return m[a[2:0]];
      if (a == 4'h8) return pa;
      if (a == 4'h9) return pb;
      if (a == 4'hA) return int'((m[2] | m[5]) != 0);
      return 0;
   endfunction : exp_rd
   task check(input logic [7:0] got, input int exp_v);
      comparisons++;
      if (got !== exp_v[7:0]) begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp_v[7:0]);
      end
   endtask : check
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      bus_req <= '0;
      case (a)
         4'h2, 4'h5: m[a] &= d;
         4'h6: m[6] &= ~d;
         4'h7: m[7] = d & 8'h03;
         4'h0, 4'h1, 4'h3, 4'h4: m[a] = d;
         default: ;
      endcase
   endtask : wr
   task rd(input logic [3:0] a);
      @(posedge sys_clk);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk);
      bus_req <= '0;
      #1 check(rd_data, exp_rd(a));
   endtask : rd
   task sweep;
      for (int a = 0; a < 12; a++) rd(4'(a));
      check({7'h00, irq}, (m[6] & m[7]) != 0);
      check({7'h00, change_interrupt_flag}, (m[2] | m[5]) != 0);
   endtask : sweep
   task automatic apply(input logic [7:0] na, input logic [7:0] nb);
      int ea, eb;
      ea = (na & ~pa & m[0]) | (~na & pa & m[1]);
      eb = (nb & ~pb & m[3]) | (~nb & pb & m[4]);
      m[2] |= ea;
      m[5] |= eb;
      if (ea != 0) m[6] |= 1;
      if (eb != 0) m[6] |= 2;
      pa = na;
      pb = nb;
      pm.drive('{nb, na});
   endtask : apply
   task reset_dut;
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      m = '{default: 0};
      pa = pins.porta;
      pb = pins.portb;
   endtask : reset_dut
   task final_report;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   initial begin
      #5_000_000;
      errors++;
      final_report;
   end
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      bus_req = '0;
      for (int p = 0; p < 2; p++) begin
         reset_dut;
         sweep;
         $display("reset test %0d done", p);
         for (int i = 0; i < 40; i++) begin
            r = rnd();
            wr(ADDR_PORTA_RISE, r[7:0]);
            wr(ADDR_PORTA_FALL, r[15:8]);
            wr(ADDR_PORTB_RISE, r[23:16]);
            wr(ADDR_PORTB_FALL, r[31:24]);
            r = rnd();
            wr(ADDR_IRQ_MASK, r[7:0]);
            wr(r[11:8], r[23:16]);
            r = rnd();
            apply(r[7:0], r[15:8]);
            repeat (6) @(posedge sys_clk);
            sweep;
            r = rnd();
            wr(ADDR_PORTA_FLAGS, r[7:0] & {8{r[24]}});
            wr(ADDR_PORTB_FLAGS, r[15:8] & {8{r[25]}});
            wr(ADDR_IRQ_STATUS, r[23:16]);
         end
         $display("random test %0d done", p);
      end
      final_report;
   end
endmodule : testbench
`default_nettype wire
